// >>> parallel_ports_dj.sv
// Parallel ports D, E, F, H and J with an APB register slave
//
// Operation
// - Alternate function owns pin; register still stored
// - Direction one drives; D/F/J directions reset zero
// - D, F, J data kept through reset
// - Port E pins inputs, undriven after reset
// - E[6:0] inputs; E top driven by DAC
// - E data read-only pin levels, writes ignored
// - Expanded mode: F drives address, unmapped
// - Single-chip F inputs with selectable pull-ups
// - H output-only; PWM pairs take over pins
// - H reads latch; H outputs low at reset
// - H short bits read one; reset zero
// - J four bits; upper bits read zero
// - J pull-up only on inputs, global enable
// - J output bits read stored data
// - J keyboard flag/mask, inputs only
// - J flag sets on selected edge
// - Edge one rising, zero falling; mask enables
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module parallel_ports_dj (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [ports_dj_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [ports_dj_pkg::DATA_W-1:0]  pwdata,
  output var  logic                             pready,
  output var  logic [ports_dj_pkg::DATA_W-1:0]  prdata,
  output var  logic                             pslverr,
  input  wire logic                             expanded_mode,
  input  wire logic                             smod,
  input  wire logic [7:0]                       addr_low,
  input  wire logic                             dac_active,
  input  wire logic                             dac_level,
  input  wire logic [ports_dj_pkg::PWM_N-1:0]   pwm_enable,
  input  wire logic [ports_dj_pkg::PWM_N-1:0]   pwm_level,
  input  wire logic [7:0]                       alt_d_en,
  input  wire ports_dj_pkg::drive8_t            alt_d_drive,
  input  wire logic [7:0]                       d_in,
  output var  ports_dj_pkg::drive8_t            d_pin,
  input  wire logic [7:0]                       e_in,
  output var  ports_dj_pkg::drive1_t            e_top_pin,
  input  wire logic [7:0]                       f_in,
  output var  ports_dj_pkg::drive8_t            f_pin,
  output var  logic [7:0]                       f_pullup,
  input  wire logic [7:0]                       h_in,
  output var  logic [7:0]                       h_out,
  input  wire logic [3:0]                       j_in,
  output var  ports_dj_pkg::drive4_t            j_pin,
  output var  logic [3:0]                       j_pullup,
  output var  logic                             kbd_request
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Output bits read the stored value, input bits the pin
  function automatic logic [7:0] read_pin(input logic [7:0] dir,
                                          input logic [7:0] data,
                                          input logic [7:0] pin);
    read_pin = (dir & data) | (~dir & pin);
  endfunction

  function automatic logic is_mapped(input logic [7:0] idx,
                                     input logic       exp_mode);
    case (idx)
      ports_dj_pkg::IDX_F_DIR,
      ports_dj_pkg::IDX_F_VAL:   is_mapped = ~exp_mode;
      ports_dj_pkg::IDX_D_VAL,
      ports_dj_pkg::IDX_D_DIR,
      ports_dj_pkg::IDX_E_VAL,
      ports_dj_pkg::IDX_PULLUP,
      ports_dj_pkg::IDX_KFLAG,
      ports_dj_pkg::IDX_KMASK,
      ports_dj_pkg::IDX_J_VAL,
      ports_dj_pkg::IDX_J_DIR,
      ports_dj_pkg::IDX_H_VAL,
      ports_dj_pkg::IDX_H_SHORT: is_mapped = 1'b1;
      default:                   is_mapped = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]              d_val_r;
  logic [7:0]              d_dir_r;
  logic [7:0]              f_val_r;
  logic [7:0]              f_dir_r;
  logic [3:0]              j_val_r;
  logic [3:0]              j_dir_r;
  logic [7:0]              h_val_r;
  logic [7:0]              h_short_r;
  logic [7:0]              pullup_r;
  logic [3:0]              kflag_r;
  logic [3:0]              kmsk_r;
  logic [3:0]              kedg_r;
  logic                    kedg_locked_r;
  ports_dj_pkg::apb_state_t state_r;

  logic [7:0]              d_s1_r, d_s2_r;
  logic [7:0]              e_s1_r, e_s2_r;
  logic [7:0]              f_s1_r, f_s2_r;
  logic [7:0]              h_s1_r, h_s2_r;
  logic [3:0]              j_s1_r, j_s2_r, j_s3_r;
  logic [7:0]              h_drv1_r, h_drv2_r;

  logic [7:0]              idx;
  logic                    wr_en;
  logic [3:0]              j_edge;
  logic [31:0]             rdata_nxt;
  logic [7:0]              h_nxt;

  assign idx   = paddr[ports_dj_pkg::ADDR_W-1:ports_dj_pkg::IDX_LSB];
  assign wr_en = psel & penable & pready & pwrite &
                 is_mapped(idx, expanded_mode);

  // ----------------------------------------------------------------
  // APB handshake: one wait-free access cycle after setup
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ports_dj_pkg::ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      case (state_r)
        ports_dj_pkg::ST_IDLE: begin
          if (psel && !penable) begin
            state_r <= ports_dj_pkg::ST_DONE;
            pready  <= 1'b1;
            pslverr <= ~is_mapped(idx, expanded_mode);
            prdata  <= pwrite ? '0 : rdata_nxt;
          end
        end
        ports_dj_pkg::ST_DONE: begin
          state_r <= ports_dj_pkg::ST_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
          prdata  <= '0;
        end
        default: begin
          state_r <= ports_dj_pkg::ST_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
          prdata  <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = '0;
    case (idx)
      ports_dj_pkg::IDX_D_VAL:
        rdata_nxt[7:0] = read_pin(d_dir_r, d_val_r, d_s2_r);
      ports_dj_pkg::IDX_D_DIR:
        rdata_nxt[7:0] = d_dir_r;
      ports_dj_pkg::IDX_E_VAL:
        rdata_nxt[7:0] = e_s2_r;
      ports_dj_pkg::IDX_F_VAL:
        if (!expanded_mode)
          rdata_nxt[7:0] = read_pin(f_dir_r, f_val_r, f_s2_r);
      ports_dj_pkg::IDX_F_DIR:
        if (!expanded_mode)
          rdata_nxt[7:0] = f_dir_r;
      ports_dj_pkg::IDX_PULLUP:
        rdata_nxt[7:0] = pullup_r;
      ports_dj_pkg::IDX_KFLAG:
        rdata_nxt[3:0] = kflag_r;
      ports_dj_pkg::IDX_KMASK:
        rdata_nxt[7:0] = {kedg_r, kmsk_r};
      ports_dj_pkg::IDX_J_VAL:
        rdata_nxt[7:0] = read_pin({4'h0, j_dir_r}, {4'h0, j_val_r},
                                  {4'h0, j_s2_r});
      ports_dj_pkg::IDX_J_DIR:
        rdata_nxt[3:0] = j_dir_r;
      ports_dj_pkg::IDX_H_VAL:
        rdata_nxt[7:0] = h_val_r;
      ports_dj_pkg::IDX_H_SHORT:
        rdata_nxt[7:0] = h_short_r;
      default:
        rdata_nxt = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Data registers, untouched by reset
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (wr_en && idx == ports_dj_pkg::IDX_D_VAL)
      d_val_r <= pwdata[7:0];
    if (wr_en && idx == ports_dj_pkg::IDX_F_VAL)
      f_val_r <= pwdata[7:0];
    if (wr_en && idx == ports_dj_pkg::IDX_J_VAL)
      j_val_r <= pwdata[3:0];
  end

  // ----------------------------------------------------------------
  // Direction, output and pull-up registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_dir_r  <= ports_dj_pkg::DIR_RST;
      f_dir_r  <= ports_dj_pkg::DIR_RST;
      j_dir_r  <= ports_dj_pkg::DIR_RST[3:0];
      h_val_r  <= ports_dj_pkg::H_RST;
      pullup_r <= ports_dj_pkg::PULLUP_RST;
    end else if (wr_en) begin
      case (idx)
        ports_dj_pkg::IDX_D_DIR:  d_dir_r  <= pwdata[7:0];
        ports_dj_pkg::IDX_F_DIR:  f_dir_r  <= pwdata[7:0];
        ports_dj_pkg::IDX_J_DIR:  j_dir_r  <= pwdata[3:0];
        ports_dj_pkg::IDX_H_VAL:  h_val_r  <= pwdata[7:0];
        ports_dj_pkg::IDX_PULLUP:
          pullup_r <= pwdata[7:0] & ports_dj_pkg::PULLUP_WM;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_s1_r <= '0;
      d_s2_r <= '0;
      e_s1_r <= '0;
      e_s2_r <= '0;
      f_s1_r <= '0;
      f_s2_r <= '0;
      h_s1_r <= '0;
      h_s2_r <= '0;
      j_s1_r <= '0;
      j_s2_r <= '0;
      j_s3_r <= '0;
    end else begin
      d_s1_r <= d_in;
      d_s2_r <= d_s1_r;
      e_s1_r <= e_in;
      e_s2_r <= e_s1_r;
      f_s1_r <= f_in;
      f_s2_r <= f_s1_r;
      h_s1_r <= h_in;
      h_s2_r <= h_s1_r;
      j_s1_r <= j_in;
      j_s2_r <= j_s1_r;
      j_s3_r <= j_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Keyboard edge detection on port J
  // ----------------------------------------------------------------
  assign j_edge = ~j_dir_r &
                  ((kedg_r & j_s2_r & ~j_s3_r) |
                   (~kedg_r & ~j_s2_r & j_s3_r));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kflag_r <= ports_dj_pkg::KBD_RST;
    end else begin
      // Write one to clear; a new edge wins over the clear
      if (wr_en && idx == ports_dj_pkg::IDX_KFLAG)
        kflag_r <= (kflag_r & ~pwdata[3:0]) | j_edge;
      else
        kflag_r <= kflag_r | j_edge;
    end
  end

  // Edge selects lock after their first write unless smod is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kmsk_r        <= ports_dj_pkg::KBD_RST;
      kedg_r        <= ports_dj_pkg::KBD_RST;
      kedg_locked_r <= 1'b0;
    end else if (wr_en && idx == ports_dj_pkg::IDX_KMASK) begin
      kmsk_r <= pwdata[3:0];
      if (!kedg_locked_r || smod) begin
        kedg_r <= pwdata[ports_dj_pkg::EDG_LSB +: 4];
        kedg_locked_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      kbd_request <= 1'b0;
    else
      kbd_request <= |(kflag_r & kmsk_r & ~j_dir_r);
  end

  // ----------------------------------------------------------------
  // Port H output with PWM takeover
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ports_dj_pkg::PWM_N; g++) begin : g_pwm
      assign h_nxt[2*g +: 2] = pwm_enable[g] ? {2{pwm_level[g]}}
                                             : h_val_r[2*g +: 2];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_out    <= ports_dj_pkg::H_RST;
      h_drv1_r <= ports_dj_pkg::H_RST;
      h_drv2_r <= ports_dj_pkg::H_RST;
    end else begin
      h_out    <= h_nxt;
      h_drv1_r <= h_out;
      h_drv2_r <= h_drv1_r;
    end
  end

  // Driven level is delayed to line up with the sampled pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      h_short_r <= ports_dj_pkg::SHORT_RST;
    else
      h_short_r <= h_short_r |
                   ((h_drv2_r ^ h_s2_r) & ~(h_drv2_r ^ h_drv1_r));
  end

  // ----------------------------------------------------------------
  // Pin drivers for ports D, E, F and J
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_pin     <= '0;
      e_top_pin <= '0;
      f_pin     <= '0;
      f_pullup  <= '0;
      j_pin     <= '0;
      j_pullup  <= '0;
    end else begin
      d_pin.lvl <= (alt_d_en & alt_d_drive.lvl) |
                   (~alt_d_en & d_val_r);
      d_pin.oe  <= (alt_d_en & alt_d_drive.oe) |
                   (~alt_d_en & d_dir_r);
      e_top_pin.oe  <= dac_active;
      e_top_pin.lvl <= dac_active & dac_level;
      if (expanded_mode) begin
        f_pin.lvl <= addr_low;
        f_pin.oe  <= '1;
        f_pullup  <= '0;
      end else begin
        f_pin.lvl <= f_val_r;
        f_pin.oe  <= f_dir_r;
        f_pullup  <= ~f_dir_r &
                     {8{pullup_r[ports_dj_pkg::PU_F_BIT]}};
      end
      j_pin.lvl <= j_val_r;
      j_pin.oe  <= j_dir_r;
      j_pullup  <= ~j_dir_r &
                   {4{pullup_r[ports_dj_pkg::PU_J_BIT]}};
    end
  end

endmodule

`default_nettype wire

// >>> pin_model.sv
// Board-side model: resolves drives, pull-ups, outside levels and shorts
`timescale 1ns/1ns
`default_nettype none

module pin_model (
  input  wire ports_dj_pkg::drive8_t d_pin,
  input  wire ports_dj_pkg::drive1_t e_top_pin,
  input  wire ports_dj_pkg::drive8_t f_pin,
  input  wire logic [7:0]            f_pullup,
  input  wire logic [7:0]            h_out,
  input  wire ports_dj_pkg::drive4_t j_pin,
  input  wire logic [3:0]            j_pullup,
  input  wire logic [7:0]            ext_d,
  input  wire logic [7:0]            ext_e,
  input  wire logic [7:0]            ext_f,
  input  wire logic [3:0]            ext_j,
  input  wire logic [7:0]            h_short,
  output var  logic [7:0]            d_in,
  output var  logic [7:0]            e_in,
  output var  logic [7:0]            f_in,
  output var  logic [7:0]            h_in,
  output var  logic [3:0]            j_in
);
  always_comb begin
    d_in = (d_pin.oe & d_pin.lvl) | (~d_pin.oe & ext_d);
    e_in = {e_top_pin.oe ? e_top_pin.lvl : ext_e[7], ext_e[6:0]};
    f_in = (f_pin.oe & f_pin.lvl) | (~f_pin.oe & (f_pullup | ext_f));
    j_in = (j_pin.oe & j_pin.lvl) | (~j_pin.oe & (j_pullup | ext_j));
    // A shorted line reads opposite to what is driven
    h_in = h_out ^ h_short;
  end
endmodule

`default_nettype wire

// >>> ports_dj_asserts.sv
// Port-level checker for the parallel port block, bound to its top
`timescale 1ns/1ns
`default_nettype none

module ports_dj_asserts (
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pready,
  input wire logic [ports_dj_pkg::DATA_W-1:0] prdata,
  input wire logic                           pslverr,
  input wire logic                           expanded_mode,
  input wire logic [7:0]                     addr_low,
  input wire logic                           dac_active,
  input wire logic                           dac_level,
  input wire logic [3:0]                     pwm_enable,
  input wire logic [3:0]                     pwm_level,
  input wire logic [7:0]                     alt_d_en,
  input wire ports_dj_pkg::drive8_t          alt_d_drive,
  input wire ports_dj_pkg::drive8_t          d_pin,
  input wire ports_dj_pkg::drive1_t          e_top_pin,
  input wire ports_dj_pkg::drive8_t          f_pin,
  input wire logic [7:0]                     h_out,
  input wire ports_dj_pkg::drive4_t          j_pin,
  input wire logic [3:0]                     j_pullup,
  input wire logic                           kbd_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Bus and pins
  // ----------------------------------------------------------------
  a_apb_answer: assert property (
    psel && !penable && !pready |=> pready) else $error("no answer");
  a_pulse_one: assert property (
    pready |=> !pready) else $error("pready held");
  a_idle_quiet: assert property (
    !pready |-> prdata == 32'h0 && !pslverr) else $error("idle data");
  a_err_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
  a_reset_low: assert property (disable iff (1'b0)
    !presetn |-> h_out == 8'h00 && d_pin.oe == 8'h00 &&
    f_pin.oe == 8'h00 && j_pin.oe == 4'h0 && !e_top_pin.oe)
    else $error("driven in reset");
  a_f_address: assert property (
    expanded_mode |=> f_pin.oe == 8'hff && f_pin.lvl == $past(addr_low))
    else $error("port F address");
  a_e_top_dac: assert property (
    1'b1 |=> e_top_pin.oe == $past(dac_active) &&
    (!e_top_pin.oe || e_top_pin.lvl == $past(dac_level)))
    else $error("port E top pin");
  a_h_pwm_pair: assert property (
    pwm_enable[0] |=> h_out[1:0] == {2{$past(pwm_level[0])}})
    else $error("pwm pair");
  a_d_alt_pin: assert property (
    |alt_d_en |=>
    ((d_pin.lvl ^ $past(alt_d_drive.lvl)) & $past(alt_d_en)) == 8'h00)
    else $error("alternate drive");
  a_j_pullup_in: assert property (
    (j_pullup & j_pin.oe) == 4'h0) else $error("pull-up on output");

  c_refused: cover property (pslverr);
  c_keyboard: cover property (kbd_request);
  c_expanded: cover property (expanded_mode && f_pin.oe == 8'hff);
endmodule

bind parallel_ports_dj ports_dj_asserts u_ports_dj_asserts (
  .pclk, .presetn, .psel, .penable, .pready, .prdata, .pslverr,
  .expanded_mode, .addr_low, .dac_active, .dac_level, .pwm_enable,
  .pwm_level, .alt_d_en, .alt_d_drive, .d_pin, .e_top_pin, .f_pin,
  .h_out, .j_pin, .j_pullup, .kbd_request);

`default_nettype wire

// >>> ports_dj_pkg.sv
// Constants, register indices and pin carriers for the parallel port block
package ports_dj_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 32;
  localparam int IDX_LSB  = 2;
  localparam int IDX_W    = 8;
  localparam int PORT_W   = 8;
  localparam int J_W      = 4;
  localparam int PWM_N    = 4;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_F_DIR   = 8'h03;
  localparam logic [IDX_W-1:0] IDX_F_VAL   = 8'h05;
  localparam logic [IDX_W-1:0] IDX_D_VAL   = 8'h08;
  localparam logic [IDX_W-1:0] IDX_D_DIR   = 8'h09;
  localparam logic [IDX_W-1:0] IDX_E_VAL   = 8'h0a;
  localparam logic [IDX_W-1:0] IDX_PULLUP  = 8'h2c;
  localparam logic [IDX_W-1:0] IDX_KFLAG   = 8'h58;
  localparam logic [IDX_W-1:0] IDX_KMASK   = 8'h59;
  localparam logic [IDX_W-1:0] IDX_J_VAL   = 8'h5a;
  localparam logic [IDX_W-1:0] IDX_J_DIR   = 8'h5b;
  localparam logic [IDX_W-1:0] IDX_H_VAL   = 8'h5c;
  localparam logic [IDX_W-1:0] IDX_H_SHORT = 8'h5d;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_RST    = 8'h00;
  localparam logic [7:0] H_RST      = 8'h00;
  localparam logic [7:0] SHORT_RST  = 8'h00;
  localparam logic [7:0] PULLUP_RST = 8'h0b;
  localparam logic [7:0] PULLUP_WM  = 8'h0b;
  localparam logic [3:0] KBD_RST    = 4'h0;
  localparam int PU_J_BIT = 3;
  localparam int PU_F_BIT = 1;
  localparam int EDG_LSB  = 4;
  localparam int E_TOP    = 7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PORT_W-1:0] lvl;
    logic [PORT_W-1:0] oe;
  } drive8_t;

  typedef struct packed {
    logic [J_W-1:0] lvl;
    logic [J_W-1:0] oe;
  } drive4_t;

  typedef struct packed {
    logic lvl;
    logic oe;
  } drive1_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } apb_state_t;

endpackage

// >>> tb_top.sv
// Self-checking bench for the parallel port block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  typedef struct packed {
    logic       w;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] ex;
  } row_t;
  localparam row_t ROWS [0:13] = '{
    '{1'b0, ports_dj_pkg::IDX_D_DIR, 8'h00, 8'h00},
    '{1'b0, ports_dj_pkg::IDX_F_DIR, 8'h00, 8'h00},
    '{1'b0, ports_dj_pkg::IDX_J_DIR, 8'h00, 8'h00},
    '{1'b0, ports_dj_pkg::IDX_H_VAL, 8'h00, 8'h00},
    '{1'b0, ports_dj_pkg::IDX_H_SHORT, 8'h00, 8'h00},
    '{1'b1, ports_dj_pkg::IDX_D_DIR, 8'hff, 8'hff},
    '{1'b1, ports_dj_pkg::IDX_D_VAL, 8'ha5, 8'ha5},
    '{1'b1, ports_dj_pkg::IDX_F_DIR, 8'hff, 8'hff},
    '{1'b1, ports_dj_pkg::IDX_F_VAL, 8'h3c, 8'h3c},
    '{1'b1, ports_dj_pkg::IDX_J_DIR, 8'hff, 8'h0f},
    '{1'b1, ports_dj_pkg::IDX_J_VAL, 8'hff, 8'h0f},
    '{1'b1, ports_dj_pkg::IDX_H_VAL, 8'h5a, 8'h5a},
    '{1'b1, ports_dj_pkg::IDX_E_VAL, 8'hff, 8'h3c},
    '{1'b1, ports_dj_pkg::IDX_H_SHORT, 8'hff, 8'h00}
  };
  logic                  pclk = 1'b0, presetn = 1'b1;
  logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]            paddr = 10'h000;
  logic [31:0]           pwdata = 32'h0, prdata, rd;
  logic                  pready, pslverr, er, kbd_request;
  logic                  expanded_mode = 1'b0, dac_active = 1'b0;
  logic                  dac_level = 1'b0;
  logic [7:0]            addr_low = 8'h00, alt_d_en = 8'h00;
  logic [3:0]            pwm_enable = 4'h0, pwm_level = 4'h0;
  ports_dj_pkg::drive8_t alt_d_drive = 16'h0000, d_pin, f_pin;
  ports_dj_pkg::drive1_t e_top_pin;
  ports_dj_pkg::drive4_t j_pin;
  logic [7:0]            d_in, e_in, f_in, h_in, f_pullup, h_out;
  logic [3:0]            j_in, j_pullup, ext_j = 4'h0;
  logic [7:0]            ext_d = 8'h00, ext_e = 8'h3c, ext_f = 8'h00;
  logic [7:0]            h_short = 8'h00;
  int                    mismatches = 0, n_checks = 0, cyc = 0;

  parallel_ports_dj u_parallel_ports_dj (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .expanded_mode(expanded_mode), .smod(1'b0), .addr_low(addr_low),
    .dac_active(dac_active), .dac_level(dac_level),
    .pwm_enable(pwm_enable), .pwm_level(pwm_level), .alt_d_en(alt_d_en),
    .alt_d_drive(alt_d_drive), .d_in(d_in), .d_pin(d_pin), .e_in(e_in),
    .e_top_pin(e_top_pin), .f_in(f_in), .f_pin(f_pin),
    .f_pullup(f_pullup), .h_in(h_in), .h_out(h_out), .j_in(j_in),
    .j_pin(j_pin), .j_pullup(j_pullup), .kbd_request(kbd_request));
  pin_model u_pin_model (.d_pin(d_pin), .e_top_pin(e_top_pin),
    .f_pin(f_pin), .f_pullup(f_pullup), .h_out(h_out), .j_pin(j_pin),
    .j_pullup(j_pullup), .ext_d(ext_d), .ext_e(ext_e), .ext_f(ext_f),
    .ext_j(ext_j), .h_short(h_short), .d_in(d_in), .e_in(e_in),
    .f_in(f_in), .h_in(h_in), .j_in(j_in));

  initial forever #5 pclk = ~pclk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    n_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, got, ex);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      chk(32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] ex,
                       input logic ee);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, ee ? 8'h00 : ex});
    chk({31'h0, er}, {31'h0, ee});
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    presetn <= 1'b0;
    wait_clk(12);
    presetn <= 1'b1;
    wait_clk(3);
    chk({24'h0, f_pullup}, 32'hff);
    chk({28'h0, j_pullup}, 32'hf);
    // Port E is read here while the DAC leaves its top pin undriven
    foreach (ROWS[i]) begin
      if (ROWS[i].w)
        apb(1'b1, ROWS[i].idx, ROWS[i].wd);
      rdchk(ROWS[i].idx, ROWS[i].ex, 1'b0);
    end
    chk({d_pin.lvl, d_pin.oe}, 32'ha5ff);
    chk({f_pin.lvl, f_pin.oe}, 32'h3cff);
    chk({24'h0, j_pin}, 32'hff);
    alt_d_en <= 8'hff;
    alt_d_drive <= 16'h00ff;
    apb(1'b1, ports_dj_pkg::IDX_D_VAL, 8'h11);
    wait_clk(2);
    chk({24'h0, d_pin.lvl}, 32'h00);
    alt_d_en <= 8'h00;
    wait_clk(2);
    chk({24'h0, d_pin.lvl}, 32'h11);
    rdchk(8'h7f, 8'h00, 1'b1);
    presetn <= 1'b0;
    wait_clk(2);
    presetn <= 1'b1;
    rdchk(ports_dj_pkg::IDX_D_DIR, 8'h00, 1'b0);
    apb(1'b1, ports_dj_pkg::IDX_D_DIR, 8'hff);
    rdchk(ports_dj_pkg::IDX_D_VAL, 8'h11, 1'b0);
    chk({28'h0, j_pullup}, 32'hf);
    apb(1'b1, ports_dj_pkg::IDX_J_DIR, 8'h03);
    wait_clk(2);
    chk({28'h0, j_pullup}, 32'hc);
    apb(1'b1, ports_dj_pkg::IDX_J_DIR, 8'h00);
    apb(1'b1, ports_dj_pkg::IDX_PULLUP, 8'h00);
    wait_clk(2);
    chk({28'h0, j_pullup}, 32'h0);
    apb(1'b1, ports_dj_pkg::IDX_KMASK, 8'h11);
    apb(1'b1, ports_dj_pkg::IDX_KMASK, 8'h01);
    rdchk(ports_dj_pkg::IDX_KMASK, 8'h11, 1'b0);
    wait_clk(6);
    apb(1'b1, ports_dj_pkg::IDX_KFLAG, 8'h0f);
    ext_j[0] <= 1'b1;
    wait_clk(8);
    chk({31'h0, kbd_request}, 32'h1);
    rdchk(ports_dj_pkg::IDX_KFLAG, 8'h01, 1'b0);
    apb(1'b1, ports_dj_pkg::IDX_KFLAG, 8'h01);
    wait_clk(2);
    chk({31'h0, kbd_request}, 32'h0);
    ext_j[0] <= 1'b0;
    wait_clk(8);
    rdchk(ports_dj_pkg::IDX_KFLAG, 8'h00, 1'b0);
    apb(1'b1, ports_dj_pkg::IDX_H_VAL, 8'h5a);
    pwm_enable <= 4'b0101;
    pwm_level <= 4'b0001;
    wait_clk(2);
    chk({24'h0, h_out}, 32'h4b);
    rdchk(ports_dj_pkg::IDX_H_VAL, 8'h5a, 1'b0);
    pwm_enable <= 4'h0;
    h_short <= 8'h04;
    wait_clk(8);
    h_short <= 8'h00;
    wait_clk(4);
    rdchk(ports_dj_pkg::IDX_H_SHORT, 8'h04, 1'b0);
    expanded_mode <= 1'b1;
    addr_low <= 8'h96;
    wait_clk(2);
    chk({f_pin.lvl, f_pin.oe}, 32'h96ff);
    rdchk(ports_dj_pkg::IDX_F_VAL, 8'h00, 1'b1);
    expanded_mode <= 1'b0;
    dac_active <= 1'b1;
    dac_level <= 1'b1;
    wait_clk(4);
    chk({30'h0, e_top_pin}, 32'h3);
    rdchk(ports_dj_pkg::IDX_E_VAL, 8'hbc, 1'b0);
    end_sim();
  end
endmodule

`default_nettype wire
